/* hw/stc_pkg.sv */
// Constants and types shared by the sensor test and configuration registers
package stc_pkg;

   // ****************************************
   // Register offsets on the serial port
   // ****************************************
   localparam logic [6:0] OFS_MOTION        = 7'h02;
   localparam logic [6:0] OFS_MIN_PIXEL     = 7'h0a;
   localparam logic [6:0] OFS_PIXEL_READOUT = 7'h0b;
   localparam logic [6:0] OFS_RESULT_0      = 7'h0c;
   localparam logic [6:0] OFS_RESULT_1      = 7'h0d;
   localparam logic [6:0] OFS_RESULT_2      = 7'h0e;
   localparam logic [6:0] OFS_RESULT_3      = 7'h0f;
   localparam logic [6:0] OFS_SELFTEST      = 7'h10;
   localparam logic [6:0] OFS_CONFIG        = 7'h11;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int POS_PIXEL_READY    = 0;
   localparam int POS_FIRST_PIXEL    = 1;
   localparam int POS_SELFTEST_START = 0;
   localparam int POS_RESOLUTION     = 7;
   localparam int POS_SLEEP_HI       = 5;
   localparam int POS_SLEEP_LO       = 4;

   // ****************************************
   // Codes and values
   // ****************************************
   localparam logic [1:0] SLEEP_NORMAL      = 2'h0;
   localparam logic [1:0] SLEEP_LEVEL_ONE   = 2'h1;
   localparam logic [1:0] SLEEP_LEVEL_THREE = 2'h3;
   localparam logic [7:0] RESULT_PASS_0     = 8'h05;
   localparam logic [7:0] RESULT_PASS_1     = 8'h9a;
   localparam logic [7:0] RESULT_PASS_2     = 8'hca;
   localparam logic [7:0] RESULT_PASS_3     = 8'h0b;
   localparam logic [7:0] BYTE_RESET        = 8'h00;
   localparam logic [7:0] MIN_PIXEL_CEILING = 8'hfe;
   localparam logic [7:0] MIN_PIXEL_START   = 8'hff;
   localparam int         NUM_PIXELS        = 484;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLOCK_HZ         = 100_000_000;
   localparam int SELFTEST_TIME_MS = 250;
   localparam int SELFTEST_CYCLES  = SELFTEST_TIME_MS * (CLOCK_HZ / 1000);

   // ****************************************
   // Serial frame bit counts
   // ****************************************
   localparam logic [4:0] LINK_ADDR_LAST  = 5'h07;
   localparam logic [4:0] LINK_DATA_FIRST = 5'h08;
   localparam logic [4:0] LINK_DATA_LAST  = 5'h0f;
   localparam logic [4:0] LINK_DONE       = 5'h10;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] value;
   } stc_pix_t;

   typedef struct packed {
      logic       highRes;
      logic [1:0] sleepSel;
   } stc_cfg_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } stc_test_state_t;

endpackage

/* hw/stc_sensor_regs.sv */
// Test, pixel readout and configuration registers behind the serial port
//
// How it works
// RULE_01: Minimum pixel of each frame is reported, clamped to 0..254.
// RULE_02: Any write to pixel readout resets the pointer to pixel 0,0; code ignores such writes while the self-test runs.
// RULE_03: One pixel per frame is loaded; pixel-ready then goes high.
// RULE_04: Each pixel readout read advances the pointer to the next pixel; code ignores such reads while the self-test runs.
// RULE_05: After the last pixel the pointer wraps and first-pixel flag rises.
// RULE_06: Passing self-test leaves 05 and 9A in result bytes 0 and 1.
// RULE_07: Passing self-test leaves CA and 0B in result bytes 2 and 3.
// RULE_08: Writing 1 to bit 0 of self-test register runs a 250 ms test.
// RULE_09: Controller stays off the serial port during the self-test.
// RULE_10: Controller resets the sensor after self-test before tracking.
// RULE_11: Sleep field 00 normal, 01 level one, 11 level three.
// RULE_12: Configuration bit 7 selects 400 (0) or 800 (1) counts per inch.
// RULE_13: Controller avoids forced sleep during normal motion.
// RULE_14: Pixel-ready clears on readout read, sets on next loaded pixel.
`timescale 1ns/10ps

module stc_sensor_regs #(
   parameter int NUM_PIXELS      = stc_pkg::NUM_PIXELS,
   parameter int SELFTEST_CYCLES = stc_pkg::SELFTEST_CYCLES
) (
   input  wire logic                            clock,
   input  wire logic                            rst,
   input  wire logic                            sclk,
   input  wire logic                            ncsN,
   input  wire logic                            mosi,
   output logic                                 misoOut,
   output logic                                 misoOeN,
   input  wire stc_pkg::stc_pix_t               pixIn,
   output logic [$clog2(NUM_PIXELS)-1:0]        pixelPointer,
   output logic                                 resolution800,
   output logic                                 sleepLevelOne,
   output logic                                 sleepLevelThree,
   output logic                                 selfTestBusy
);

   localparam int PTR_W = $clog2(NUM_PIXELS);
   localparam int CNT_W = $clog2(SELFTEST_CYCLES + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(NUM_PIXELS - 1);
   localparam logic [PTR_W-1:0] PTR_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SELFTEST_CYCLES - 1);

   if (NUM_PIXELS < 2 || SELFTEST_CYCLES < 1) begin : gBadParams
      $error("stc_sensor_regs: NUM_PIXELS must be 2 or more, SELFTEST_CYCLES 1 or more");
   end

   // ****************************************
   // Serial link, sclk domain
   // ****************************************
   logic [4:0]  bitCnt;
   logic [7:0]  inShift;
   logic [6:0]  linkAddr;
   logic        isWrite;
   logic [6:0]  rdAddrHold;
   logic [6:0]  wrAddrHold;
   logic [7:0]  wrDataHold;
   logic        rdTgl;
   logic        wrTgl;
   logic [7:0]  outShift;
   logic [7:0]  readData;

   // Idle frame clears the bit count without needing an sclk edge
   wire         linkIdle   = rst | ncsN;
   wire [7:0]   nextIn     = {inShift[6:0], mosi};
   wire         addrDone   = (bitCnt == stc_pkg::LINK_ADDR_LAST);
   wire         dataDone   = (bitCnt == stc_pkg::LINK_DATA_LAST);
   wire [4:0]   next_bitCnt = (bitCnt == stc_pkg::LINK_DONE) ? bitCnt : bitCnt + 5'h01;
   wire         readStart  = !isWrite && (bitCnt == stc_pkg::LINK_DATA_FIRST);
   wire         readShift  = !isWrite && (bitCnt > stc_pkg::LINK_DATA_FIRST)
                             && (bitCnt < stc_pkg::LINK_DONE);

   always_ff @(posedge sclk or posedge linkIdle) begin
      if (linkIdle) begin
         bitCnt   <= 5'h00;
         inShift  <= stc_pkg::BYTE_RESET;
         linkAddr <= 7'h00;
         isWrite  <= 1'b0;
      end else begin
         bitCnt  <= next_bitCnt;
         inShift <= nextIn;
         if (addrDone) begin
            linkAddr <= nextIn[6:0];
            isWrite  <= nextIn[7];
         end
      end
   end

   // Toggles survive chip-select so no event is faked between frames
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         rdTgl      <= 1'b0;
         wrTgl      <= 1'b0;
         rdAddrHold <= 7'h00;
         wrAddrHold <= 7'h00;
         wrDataHold <= stc_pkg::BYTE_RESET;
      end else begin
         if (addrDone && !nextIn[7]) begin
            rdAddrHold <= nextIn[6:0];
            rdTgl      <= ~rdTgl;
         end
         if (dataDone && isWrite) begin
            wrAddrHold <= linkAddr;
            wrDataHold <= nextIn;
            wrTgl      <= ~wrTgl;
         end
      end
   end

   // Read byte must already be settled in the core when data phase starts
   always_ff @(negedge sclk or posedge linkIdle) begin
      if (linkIdle) begin
         misoOut  <= 1'b0;
         misoOeN  <= 1'b1;
         outShift <= stc_pkg::BYTE_RESET;
      end else if (readStart) begin
         misoOut  <= readData[7];
         misoOeN  <= 1'b0;
         outShift <= {readData[6:0], 1'b0};
      end else if (readShift) begin
         misoOut  <= outShift[7];
         outShift <= {outShift[6:0], 1'b0};
      end
   end

   // ****************************************
   // Crossing into the core clock
   // ****************************************
   logic [2:0]  rdSync;
   logic [2:0]  wrSync;
   logic [6:0]  wrAddr;
   logic [7:0]  wrData;
   logic        wrEvt;

   always_ff @(posedge clock) begin
      if (rst) begin
         rdSync <= 3'h0;
         wrSync <= 3'h0;
      end else begin
         rdSync <= {rdSync[1:0], rdTgl};
         wrSync <= {wrSync[1:0], wrTgl};
      end
   end

   wire rdEvt   = rdSync[2] ^ rdSync[1];
   wire wrArriv = wrSync[2] ^ wrSync[1];

   // Hold words are stable well before their toggle is seen here
   always_ff @(posedge clock) begin
      if (rst) begin
         wrAddr <= 7'h00;
         wrData <= stc_pkg::BYTE_RESET;
         wrEvt  <= 1'b0;
      end else begin
         wrEvt <= wrArriv;
         if (wrArriv) begin
            wrAddr <= wrAddrHold;
            wrData <= wrDataHold;
         end
      end
   end

   // ****************************************
   // Decode
   // ****************************************
   stc_pkg::stc_test_state_t testState;
   logic [CNT_W-1:0] testCnt;
   logic [7:0]       result0;
   logic [7:0]       result1;
   logic [7:0]       result2;
   logic [7:0]       result3;
   stc_pkg::stc_cfg_t cfg;
   logic [7:0]       minimumPixel;
   logic [7:0]       runMin;
   logic [7:0]       pixelData;
   logic [PTR_W-1:0] pixIdx;
   logic             pixelReady;
   logic             firstPixel;
   logic             grabActive;

   // Writes and pixel readout reads during the test are ignored, the controller keeps off
   // RULE_09 quiet port
   wire testIdle   = (testState == stc_pkg::ST_IDLE);
   wire wrPixel    = wrEvt && testIdle && (wrAddr == stc_pkg::OFS_PIXEL_READOUT);
   wire wrConfig   = wrEvt && testIdle && (wrAddr == stc_pkg::OFS_CONFIG);
   wire wrSelfTest = wrEvt && testIdle && (wrAddr == stc_pkg::OFS_SELFTEST)
                     && wrData[stc_pkg::POS_SELFTEST_START];
   wire rdPixel    = rdEvt && testIdle && (rdAddrHold == stc_pkg::OFS_PIXEL_READOUT);
   wire testDone   = !testIdle && (testCnt == CNT_LAST);

   wire [7:0] motionByte = (8'(pixelReady) << stc_pkg::POS_PIXEL_READY)
                         | (8'(firstPixel) << stc_pkg::POS_FIRST_PIXEL);
   wire [7:0] cfgByte    = (8'(cfg.highRes) << stc_pkg::POS_RESOLUTION)
                         | (8'(cfg.sleepSel) << stc_pkg::POS_SLEEP_LO);
   wire [7:0] rdMux =
      (rdAddrHold == stc_pkg::OFS_MOTION)        ? motionByte   :
      (rdAddrHold == stc_pkg::OFS_MIN_PIXEL)     ? minimumPixel :
      (rdAddrHold == stc_pkg::OFS_PIXEL_READOUT) ? pixelData    :
      (rdAddrHold == stc_pkg::OFS_RESULT_0)      ? result0      :
      (rdAddrHold == stc_pkg::OFS_RESULT_1)      ? result1      :
      (rdAddrHold == stc_pkg::OFS_RESULT_2)      ? result2      :
      (rdAddrHold == stc_pkg::OFS_RESULT_3)      ? result3      :
      (rdAddrHold == stc_pkg::OFS_CONFIG)        ? cfgByte      : stc_pkg::BYTE_RESET;

   always_ff @(posedge clock) begin
      if (rst) begin
         readData <= stc_pkg::BYTE_RESET;
      end else if (rdEvt) begin
         readData <= rdMux;
      end
   end

   // ****************************************
   // Minimum pixel statistic
   // ****************************************
   wire [7:0] frameMin  = (pixIn.value < runMin) ? pixIn.value : runMin;
   // RULE_01 clamp to 254
   wire [7:0] next_minimumPixel =
      (frameMin > stc_pkg::MIN_PIXEL_CEILING) ? stc_pkg::MIN_PIXEL_CEILING : frameMin;

   always_ff @(posedge clock) begin
      if (rst) begin
         runMin       <= stc_pkg::MIN_PIXEL_START;
         minimumPixel <= stc_pkg::BYTE_RESET;
         pixIdx       <= PTR_ZERO;
      end else if (pixIn.valid) begin
         runMin       <= pixIn.last ? stc_pkg::MIN_PIXEL_START : frameMin;
         minimumPixel <= pixIn.last ? next_minimumPixel : minimumPixel;
         pixIdx       <= pixIn.last ? PTR_ZERO : pixIdx + PTR_W'(1);
      end
   end

   // ****************************************
   // Pixel grab
   // ****************************************
   // Capture is skipped for that pixel if a readout read or write lands in the same cycle
   // RULE_03 one pixel per frame
   wire capture  = grabActive && !pixelReady && !rdPixel && !wrPixel
                   && pixIn.valid && (pixIdx == pixelPointer);
   wire wrapNow  = rdPixel && (pixelPointer == PTR_LAST);
   wire [PTR_W-1:0] next_pixelPointer =
      wrPixel ? PTR_ZERO : (wrapNow ? PTR_ZERO : pixelPointer + PTR_W'(1));

   always_ff @(posedge clock) begin
      if (rst) begin
         pixelPointer <= PTR_ZERO;
         grabActive   <= 1'b0;
         pixelData    <= stc_pkg::BYTE_RESET;
      end else begin
         // RULE_02 RULE_04 pointer moves
         if (wrPixel || rdPixel) begin
            pixelPointer <= next_pixelPointer;
         end
         if (wrPixel) begin
            grabActive <= 1'b1;
         end
         if (capture) begin
            pixelData <= pixIn.value;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pixelReady <= 1'b0;
         firstPixel <= 1'b0;
      end else begin
         // RULE_14 ready set or cleared
         pixelReady <= capture || (pixelReady && !rdPixel && !wrPixel);
         // RULE_05 wrap flag
         firstPixel <= wrapNow || (firstPixel && !rdPixel && !wrPixel);
      end
   end

   // ****************************************
   // Self-test
   // ****************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         testState <= stc_pkg::ST_IDLE;
         testCnt   <= '0;
      end else begin
         case (testState)
            // RULE_08 start test
            stc_pkg::ST_IDLE: begin
               testCnt <= '0;
               if (wrSelfTest) begin
                  testState <= stc_pkg::ST_RUN;
               end
            end
            stc_pkg::ST_RUN: begin
               testCnt <= testCnt + CNT_W'(1);
               if (testDone) begin
                  testState <= stc_pkg::ST_IDLE;
               end
            end
            default: begin
               testState <= stc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Results persist; normal tracking needs a chip reset afterwards
   // RULE_06 RULE_07 pass results
   always_ff @(posedge clock) begin
      if (rst) begin
         result0 <= stc_pkg::BYTE_RESET;
         result1 <= stc_pkg::BYTE_RESET;
         result2 <= stc_pkg::BYTE_RESET;
         result3 <= stc_pkg::BYTE_RESET;
      end else if (testDone) begin
         result0 <= stc_pkg::RESULT_PASS_0;
         result1 <= stc_pkg::RESULT_PASS_1;
         result2 <= stc_pkg::RESULT_PASS_2;
         result3 <= stc_pkg::RESULT_PASS_3;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         selfTestBusy <= 1'b0;
      end else begin
         selfTestBusy <= (testIdle && wrSelfTest) || (!testIdle && !testDone);
      end
   end

   // ****************************************
   // Configuration
   // ****************************************
   stc_pkg::stc_cfg_t next_cfg;
   assign next_cfg.highRes  = wrData[stc_pkg::POS_RESOLUTION];
   assign next_cfg.sleepSel = wrData[stc_pkg::POS_SLEEP_HI:stc_pkg::POS_SLEEP_LO];

   // Code 10 is undefined and runs as normal
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg             <= '0;
         resolution800   <= 1'b0;
         sleepLevelOne   <= 1'b0;
         sleepLevelThree <= 1'b0;
      end else if (wrConfig) begin
         cfg             <= next_cfg;
         // RULE_12 resolution select
         resolution800   <= next_cfg.highRes;
         // RULE_11 sleep decode
         sleepLevelOne   <= (next_cfg.sleepSel == stc_pkg::SLEEP_LEVEL_ONE);
         sleepLevelThree <= (next_cfg.sleepSel == stc_pkg::SLEEP_LEVEL_THREE);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   AST_MIN_RANGE: assert property (@(posedge clock) disable iff (rst) // RULE_01
      pixIn.valid && pixIn.last |=> minimumPixel <= stc_pkg::MIN_PIXEL_CEILING
         && minimumPixel <= $past(pixIn.value))
      else $error("minimum pixel out of range");

   AST_WRITE_RESETS_POINTER: assert property (@(posedge clock) disable iff (rst) // RULE_02
      wrPixel |=> pixelPointer == PTR_ZERO && grabActive && !pixelReady)
      else $error("pixel write did not restart grab");

   AST_READY_AFTER_LOAD: assert property (@(posedge clock) disable iff (rst) // RULE_03
      capture |=> pixelReady && pixelData == $past(pixIn.value))
      else $error("loaded pixel not flagged ready");

   AST_READ_ADVANCES: assert property (@(posedge clock) disable iff (rst) // RULE_04
      rdPixel && !wrPixel && pixelPointer != PTR_LAST
         |=> pixelPointer == $past(pixelPointer) + PTR_W'(1))
      else $error("pointer did not advance on read");

   AST_WRAP_FIRST: assert property (@(posedge clock) disable iff (rst) // RULE_05
      wrapNow && !wrPixel |=> pixelPointer == PTR_ZERO && firstPixel)
      else $error("pointer wrap missing first-pixel flag");

   AST_RESULT_LOW: assert property (@(posedge clock) disable iff (rst) // RULE_06
      testDone |=> result0 == stc_pkg::RESULT_PASS_0 && result1 == stc_pkg::RESULT_PASS_1
         && testIdle)
      else $error("result bytes 0 and 1 wrong");

   AST_RESULT_HIGH: assert property (@(posedge clock) disable iff (rst) // RULE_07
      testDone |=> result2 == stc_pkg::RESULT_PASS_2 && result3 == stc_pkg::RESULT_PASS_3)
      else $error("result bytes 2 and 3 wrong");

   AST_TEST_START: assert property (@(posedge clock) disable iff (rst) // RULE_08
      wrSelfTest |=> selfTestBusy && !testIdle ##1 selfTestBusy)
      else $error("self-test did not start");

   AST_SLEEP_DECODE: assert property (@(posedge clock) disable iff (rst) // RULE_11
      wrConfig |=> sleepLevelOne == ($past(next_cfg.sleepSel) == stc_pkg::SLEEP_LEVEL_ONE)
         && sleepLevelThree == ($past(next_cfg.sleepSel) == stc_pkg::SLEEP_LEVEL_THREE))
      else $error("sleep field decoded wrongly");

   AST_RESOLUTION: assert property (@(posedge clock) disable iff (rst) // RULE_12
      wrConfig |=> resolution800 == $past(wrData[stc_pkg::POS_RESOLUTION])
         && cfg.highRes == resolution800)
      else $error("resolution bit not applied");

   AST_READY_CLEARS: assert property (@(posedge clock) disable iff (rst) // RULE_14
      rdPixel |=> !pixelReady)
      else $error("pixel-ready not cleared by read");

endmodule

/* verification/stc_host_model.sv */
// Serial port controller model driving the sensor registers
`timescale 1ns/10ps

module stc_host_model #(
   parameter int GUARD_NS = 1000
) (
   output logic     sclk,
   output logic     ncsN,
   output logic     mosi,
   input wire logic misoOut,
   input wire logic misoOeN
);
   realtime   quietUntil;
   wire logic misoWire;

   // Undriven line floats; sampled on every bit, also while the device does not drive it
   assign misoWire = misoOeN ? 1'bz : misoOut;

   initial begin
      sclk = 1'b1;
      ncsN = 1'b1;
      mosi = 1'b0;
      quietUntil = 0;
   end

   // ****************************************
   // Byte shifter, clock idles high
   // ****************************************
   task automatic shiftByte(input logic [7:0] txByte, output logic [7:0] rxByte);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b0;
         mosi = txByte[i];
         #32;
         sclk = 1'b1;
         rxByte[i] = misoWire;
         #32;
      end
   endtask

   // ****************************************
   // One register access
   // ****************************************
   task automatic access(input logic isWrite, input logic [6:0] addr,
                         input logic [7:0] wrData, output logic [7:0] rdData);
      logic [7:0] junk;
      while ($realtime < quietUntil) #10;
      #3.7;
      ncsN = 1'b0;
      #20;
      shiftByte({isWrite, addr}, junk);
      // Pause lets the read data settle in the core
      if (!isWrite) #200;
      shiftByte(wrData, rdData);
      #20;
      ncsN = 1'b1;
      mosi = ~mosi;
      #150;
      if (isWrite && addr == stc_pkg::OFS_SELFTEST && wrData[0]) quietUntil = $realtime + GUARD_NS;
   endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the sensor test and configuration registers
`timescale 1ns/10ps

module testbench;
   localparam int NPIX  = 16;
   localparam int STCYC = 20;

   logic                     clock;
   logic                     rst;
   wire logic                sclk;
   wire logic                ncsN;
   wire logic                mosi;
   logic                     misoOut;
   logic                     misoOeN;
   stc_pkg::stc_pix_t        pixIn;
   logic [$clog2(NPIX)-1:0]  pixelPointer;
   logic                     resolution800;
   logic                     sleepLevelOne;
   logic                     sleepLevelThree;
   logic                     selfTestBusy;
   int                       failures;
   int                       cmpCount;
   int                       busyCycles = 0;
   int                       seedDummy;
   logic [7:0]               frame [NPIX];
   logic [7:0]               cfgVal;
   logic [6:0]               regList [8] = '{stc_pkg::OFS_MOTION, stc_pkg::OFS_MIN_PIXEL,
      stc_pkg::OFS_PIXEL_READOUT, stc_pkg::OFS_RESULT_0, stc_pkg::OFS_RESULT_1,
      stc_pkg::OFS_RESULT_2, stc_pkg::OFS_RESULT_3, 7'h20};

   stc_sensor_regs #(.NUM_PIXELS(NPIX), .SELFTEST_CYCLES(STCYC)) dut (
      .clock(clock), .rst(rst), .sclk(sclk), .ncsN(ncsN), .mosi(mosi),
      .misoOut(misoOut), .misoOeN(misoOeN), .pixIn(pixIn), .pixelPointer(pixelPointer),
      .resolution800(resolution800), .sleepLevelOne(sleepLevelOne),
      .sleepLevelThree(sleepLevelThree), .selfTestBusy(selfTestBusy));

   stc_host_model #(.GUARD_NS(STCYC * 10 + 500)) host (
      .sclk(sclk), .ncsN(ncsN), .mosi(mosi), .misoOut(misoOut), .misoOeN(misoOeN));

   initial clock = 1'b0;
   always #5 clock = ~clock;

   always @(posedge clock) begin
      if (selfTestBusy === 1'b1) busyCycles <= busyCycles + 1;
   end

   // ****************************************
   // Compare and access helpers
   // ****************************************
   task automatic checkByte(input logic [7:0] expV, input logic [7:0] gotV);
      cmpCount++;
      if (gotV !== expV) begin
         failures++;
         $display("ERROR t=%0t exp=%h got=%h", $time, expV, gotV);
      end
   endtask

   task automatic checkPort(input logic [8:0] expV, input logic [8:0] gotV);
      cmpCount++;
      if (gotV !== expV) begin
         failures++;
         $display("ERROR t=%0t exp=%h got=%h", $time, expV, gotV);
      end
   endtask

   task automatic regRd(input logic [6:0] a, input logic [7:0] expV);
      logic [7:0] v;
      host.access(1'b0, a, 8'($urandom), v);
      checkByte(expV, v);
   endtask

   task automatic regWr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] v;
      host.access(1'b1, a, d, v);
      repeat (10) @(posedge clock);
      #1;
   endtask

   task automatic sendFrame(input int mode);
      for (int i = 0; i < NPIX; i++) frame[i] = (mode == 1) ? 8'hff : 8'($urandom);
      if (mode == 2) frame[$urandom % NPIX] = 8'h00;
      for (int i = 0; i < NPIX; i++) begin
         @(posedge clock);
         #1;
         pixIn = '{valid: 1'b1, last: (i == NPIX - 1), value: frame[i]};
      end
      @(posedge clock);
      #1;
      pixIn = '{valid: 1'b0, last: 1'b0, value: 8'($urandom)};
      repeat (4) @(posedge clock);
      #1;
   endtask

   function automatic logic [7:0] frameMin();
      logic [7:0] m;
      m = 8'hff;
      for (int i = 0; i < NPIX; i++) if (frame[i] < m) m = frame[i];
      return (m > 8'hfe) ? 8'hfe : m;
   endfunction

   task automatic resetDut();
      rst = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      rst = 1'b0;
      repeat (5) @(posedge clock);
      #1;
   endtask

   task automatic wrap_up();
      if (failures == 0 && cmpCount > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seedDummy = $urandom(5979);
      failures = 0;
      cmpCount = 0;
      rst = 1'b1;
      pixIn = '0;
      resetDut();
      foreach (regList[i]) regRd(regList[i], 8'h00);
      for (int m = 0; m < 4; m++) begin
         sendFrame(m % 3);
         regRd(stc_pkg::OFS_MIN_PIXEL, frameMin());
      end
      regWr(stc_pkg::OFS_PIXEL_READOUT, 8'($urandom));
      for (int k = 0; k < NPIX + 3; k++) begin
         sendFrame(0);
         regRd(stc_pkg::OFS_MOTION, (k == NPIX) ? 8'h03 : 8'h01);
         regRd(stc_pkg::OFS_PIXEL_READOUT, frame[k % NPIX]);
         checkPort(9'((k + 1) % NPIX), 9'(pixelPointer));
         regRd(stc_pkg::OFS_MOTION, (k == NPIX - 1) ? 8'h02 : 8'h00);
      end
      regWr(stc_pkg::OFS_PIXEL_READOUT, 8'($urandom));
      checkPort(9'h000, 9'(pixelPointer));
      regRd(stc_pkg::OFS_MOTION, 8'h00);
      for (int c = 0; c < 8; c++) begin
         cfgVal = 8'($urandom);
         cfgVal[7] = c[2];
         cfgVal[5:4] = c[1:0];
         // sleep codes set only while idle
         regWr(stc_pkg::OFS_CONFIG, cfgVal);
         checkPort(9'(c[2]), 9'(resolution800));
         checkPort({7'h0, c[1:0] == 2'h1, c[1:0] == 2'h3},
                   {7'h0, sleepLevelOne, sleepLevelThree});
         regRd(stc_pkg::OFS_CONFIG, cfgVal & 8'hb0);
      end
      regWr(stc_pkg::OFS_SELFTEST, 8'hfe);
      checkPort(9'h000, 9'(busyCycles));
      regWr(stc_pkg::OFS_SELFTEST, 8'($urandom) | 8'h01);
      regRd(stc_pkg::OFS_RESULT_0, stc_pkg::RESULT_PASS_0);
      regRd(stc_pkg::OFS_RESULT_1, stc_pkg::RESULT_PASS_1);
      regRd(stc_pkg::OFS_RESULT_2, stc_pkg::RESULT_PASS_2);
      regRd(stc_pkg::OFS_RESULT_3, stc_pkg::RESULT_PASS_3);
      checkPort(9'(STCYC), 9'(busyCycles));
      resetDut();
      regRd(stc_pkg::OFS_RESULT_2, 8'h00);
      wrap_up();
   end

   // Generous bound; the sequence needs roughly a quarter of it
   initial begin
      #(60000 * 10);
      failures++;
      wrap_up();
   end
endmodule
